// *** shared/dbg_lock_defines.vh ***
// Constants for the debug command decoder and the flash lock byte.
// Included by the lock protection and decoder design files, not the pin synchroniser; definitions only.
`ifndef DBG_LOCK_DEFINES_VH
`define DBG_LOCK_DEFINES_VH

// Command bytes (decoder compares bits 7:3 only)
`define CMD_MASS_ERASE 8'h10
`define CMD_CFG_WRITE 8'h19
`define CMD_CFG_READ 8'h24
`define CMD_PC_READ 8'h28
`define CMD_STATUS_READ 8'h30
`define CMD_BREAKPOINT_SET 8'h3F
`define CMD_HALT 8'h44
`define CMD_RESUME 8'h4C
`define CMD_SINGLE_STEP 8'h5C
`define CMD_ID_READ 8'h68
// Commands whose low two bits carry the instruction length
`define CMD_INJECT_TOP 6'h15
`define CMD_REPLACE_TOP 6'h19

// Command byte fields
`define CMD_RETURN_BIT 2
`define CMD_COUNT_HI 1
`define CMD_COUNT_LO 0

// Lock byte fields and its place in the information page
`define LOCK_INFO_ADDR 11'h000
`define LOCK_DEBUG_BIT 0
`define LOCK_SIZE_HI 3
`define LOCK_SIZE_LO 1
`define LOCK_BOOT_BIT 4
`define LOCK_RESET 8'h00
`define BOOT_PAGE_END 17'h007FF
`define PAGE_HI 16
`define PAGE_LO 11

// Debug configuration and status
`define CFG_INFO_BIT 0
`define CFG_RESET 8'h00
`define STAT_LOCKED_BIT 2

// Identity returned by the identity read (arbitrary values)
`define CHIP_ID_VALUE 8'h5A
`define CHIP_VERSION_VALUE 8'h01

`endif

// *** hdl/pin_sync.v ***
// Two-flop synchroniser for the debug clock and data pins.
// Assumes both pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] pin_in,
  output reg [1:0] pin_out
);
  reg [1:0] meta_q;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 2'h0;
      pin_out <= 2'h0;
    end else begin
      meta_q <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** hdl/lock_protect.v ***
// Flash write protection decode from the latched lock byte.
// Assumes a 128 KB main array of 2 KB pages; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "dbg_lock_defines.vh"
module lock_protect (
  input wire [7:0] lock_byte,
  input wire info_sel,
  input wire [16:0] wr_addr,
  output reg wr_ok
);
  wire [5:0] page;
  reg [5:0] first_page;
  reg none_locked;

  assign page = wr_addr[`PAGE_HI:`PAGE_LO];

  always @* begin
    none_locked = 1'b0;
    case (lock_byte[`LOCK_SIZE_HI:`LOCK_SIZE_LO])
      3'h0: first_page = 6'h00;
      3'h1: first_page = 6'h20;
      3'h2: first_page = 6'h30;
      3'h3: first_page = 6'h38;
      3'h4: first_page = 6'h3C;
      3'h5: first_page = 6'h3E;
      3'h6: first_page = 6'h3F;
      default: begin
        first_page = 6'h3F;
        none_locked = 1'b1;
      end
    endcase
    wr_ok = none_locked | (page < first_page);
    // Size 000 already covers page 0, so a set boot bit cannot free it
    if (wr_addr <= `BOOT_PAGE_END && !lock_byte[`LOCK_BOOT_BIT]) begin
      wr_ok = 1'b0;
    end
    // The lock byte itself lives in the info page and must stay writable
    if (info_sel) begin
      wr_ok = 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** hdl/debug_lock_command_decoder.v ***
// Two-wire debug port command decoder with flash lock gating.
// Assumes debug mode is already entered, CPU and flash controller
// sit on core_clk, and the lock byte input mirrors info page 0x000.
`timescale 1ns/1ps
`default_nettype none
`include "dbg_lock_defines.vh"
// Overview of operation
// - Lock settings come from info page byte zero, not a register.
// - Info page is reachable only via debug configuration, never CPU.
// - Size field bits 3:1 protect a top-of-flash area, 000 all, 111 none.
// - Boot bit 0 protects page 0; 1 frees it unless size is 000.
// - Boot page spans byte addresses 0 to 0x07FF.
// - With debug bit 0 only erase, status and identity commands work.
// - Reported lock refreshes on halt, resume, inject, step, replace or reset.
// - Mass erase 0x10 clears lock; dies after any non-status command.
// - Lock written via normal flash write with info page selected.
// - Command 0x19 writes configuration, 0x24 reads it back.
// - Command 0x28 returns the 16-bit program counter, always two bytes.
// - Command 0x34 returns status including the lock state.
// - 0x44 halts, 0x4C resumes; resume only while halted.
// - Inject 0101 01yy runs host instruction, PC unchanged, CPU halted.
// - Step 0x5C runs next instruction and advances PC while halted.
// - Replace 0110 01yy runs host instruction instead, PC advances.
// - Command 0x68 returns identity and version, always two bytes.
// - Command byte: code 7:3, return bit 2, following bytes 1:0.
// - Bytes move most significant bit first.
// - Configuration bit 0 routes flash access to the info page.
// - Status bit 2 shows latched lock, 1 meaning locked.
module debug_lock_command_decoder (
  input wire core_clk,
  input wire rst_n,
  input wire dbg_clk_pin,
  input wire dbg_data_in,
  output wire dbg_data_out,
  output wire dbg_data_oe_n,
  input wire cpu_halted,
  input wire cpu_idle,
  input wire power_mode0,
  input wire halt_by_breakpoint,
  input wire osc_stable,
  input wire stack_overflow,
  input wire erase_done,
  input wire [15:0] pc_value,
  input wire [7:0] lock_byte_in,
  input wire flash_wr_req,
  input wire [16:0] flash_wr_addr,
  output wire halt_req,
  output wire resume_req,
  output wire inject_req,
  output wire step_req,
  output wire replace_req,
  output wire [1:0] instr_len,
  output wire [23:0] instr_bytes,
  output wire erase_req,
  output wire info_page_select,
  output wire flash_wr_grant,
  output wire flash_wr_denied,
  output wire debug_locked
);
  localparam ST_CMD = 2'h0;
  localparam ST_ARG = 2'h1;
  localparam ST_EXEC = 2'h2;
  localparam ST_RESP = 2'h3;

  wire [1:0] pins_s;
  wire clk_s;
  wire data_s;
  reg clk_prev_q;
  wire clk_rise;
  wire clk_fall;

  reg [1:0] state_q;
  reg [6:0] shift_q;
  reg [2:0] bit_cnt_q;
  reg [7:0] cmd_q;
  reg [1:0] arg_left_q;
  reg [23:0] arg_q;
  reg [1:0] resp_left_q;
  reg [15:0] resp_q;
  reg out_q;
  reg oe_n_q;

  reg [7:0] cfg_q;
  reg [7:0] lock_q;
  reg load_pend_q;
  reg erase_ok_q;

  reg halt_q;
  reg resume_q;
  reg inject_q;
  reg step_q;
  reg replace_q;
  reg erase_q;
  reg [1:0] len_q;
  reg [23:0] instr_q;
  reg grant_q;
  reg denied_q;

  wire [7:0] byte_in;
  wire locked;
  wire wr_ok;

  // Decode of the held command
  wire [7:0] cmd_code;
  wire is_erase;
  wire is_status;
  wire is_id;
  wire is_pc;
  wire is_cfg_wr;
  wire is_cfg_rd;
  wire is_halt;
  wire is_resume;
  wire is_step;
  wire is_inject;
  wire is_replace;
  wire is_cpu_cmd;
  wire lock_ok;
  wire halt_ok;
  wire accept;
  wire two_bytes;
  wire [7:0] status_byte;
  reg [15:0] resp_d;

  pin_sync u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in({dbg_clk_pin, dbg_data_in}),
    .pin_out(pins_s)
  );

  assign clk_s = pins_s[1];
  assign data_s = pins_s[0];
  assign clk_rise = clk_s & ~clk_prev_q;
  assign clk_fall = ~clk_s & clk_prev_q;

  assign byte_in = {shift_q, data_s};
  assign locked = ~lock_q[`LOCK_DEBUG_BIT];

  // Instruction code only; byte count never selects the command, return bit 2 only for inject and replace
  assign cmd_code = {cmd_q[7:3], 3'h0};
  assign is_erase = (cmd_code == (`CMD_MASS_ERASE & 8'hF8));
  assign is_status = (cmd_code == (`CMD_STATUS_READ & 8'hF8));
  assign is_id = (cmd_code == (`CMD_ID_READ & 8'hF8));
  assign is_pc = (cmd_code == (`CMD_PC_READ & 8'hF8));
  assign is_cfg_wr = (cmd_code == (`CMD_CFG_WRITE & 8'hF8));
  assign is_cfg_rd = (cmd_code == (`CMD_CFG_READ & 8'hF8));
  assign is_halt = (cmd_code == (`CMD_HALT & 8'hF8));
  assign is_resume = (cmd_code == (`CMD_RESUME & 8'hF8));
  assign is_step = (cmd_code == (`CMD_SINGLE_STEP & 8'hF8));
  assign is_inject = (cmd_q[7:2] == `CMD_INJECT_TOP);
  assign is_replace = (cmd_q[7:2] == `CMD_REPLACE_TOP);
  assign is_cpu_cmd = is_halt | is_resume | is_step | is_inject | is_replace;

  // Only three commands survive a locked port
  assign lock_ok = ~locked | is_erase | is_status | is_id;
  // Resume, step and both injections need a halted CPU
  assign halt_ok = cpu_halted | ~(is_resume | is_step | is_inject | is_replace);
  assign accept = lock_ok & halt_ok;
  assign two_bytes = is_pc | is_id;

  assign status_byte = {erase_done, cpu_idle, cpu_halted, power_mode0,
                        halt_by_breakpoint, locked, osc_stable,
                        stack_overflow};

  always @* begin
    resp_d = 16'h0000;
    if (accept) begin
      if (is_status) begin
        resp_d = {status_byte, 8'h00};
      end else if (is_cfg_rd) begin
        resp_d = {cfg_q, 8'h00};
      end else if (is_pc) begin
        resp_d = pc_value;
      end else if (is_id) begin
        resp_d = {`CHIP_ID_VALUE, `CHIP_VERSION_VALUE};
      end
    end
  end

  lock_protect u_lock_protect (
    .lock_byte(lock_q),
    .info_sel(cfg_q[`CFG_INFO_BIT]),
    .wr_addr(flash_wr_addr),
    .wr_ok(wr_ok)
  );

  // Serial byte engine: host data sampled on falling debug clock,
  // answer bits driven on rising debug clock.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
      state_q <= ST_CMD;
      shift_q <= 7'h00;
      bit_cnt_q <= 3'h0;
      cmd_q <= 8'h00;
      arg_left_q <= 2'h0;
      arg_q <= 24'h000000;
      resp_left_q <= 2'h0;
      resp_q <= 16'h0000;
      out_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      clk_prev_q <= clk_s;
      case (state_q)
        ST_CMD: begin
          if (clk_fall) begin
            shift_q <= byte_in[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              cmd_q <= byte_in;
              arg_left_q <= byte_in[`CMD_COUNT_HI:`CMD_COUNT_LO];
              arg_q <= 24'h000000;
              if (byte_in[`CMD_COUNT_HI:`CMD_COUNT_LO] == 2'h0) begin
                state_q <= ST_EXEC;
              end else begin
                state_q <= ST_ARG;
              end
            end
          end
        end
        ST_ARG: begin
          if (clk_fall) begin
            shift_q <= byte_in[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              arg_q <= {arg_q[15:0], byte_in};
              arg_left_q <= arg_left_q - 2'h1;
              if (arg_left_q == 2'h1) begin
                state_q <= ST_EXEC;
              end
            end
          end
        end
        ST_EXEC: begin
          resp_q <= resp_d;
          if (two_bytes) begin
            resp_left_q <= 2'h2;
            state_q <= ST_RESP;
          end else if (cmd_q[`CMD_RETURN_BIT]) begin
            resp_left_q <= 2'h1;
            state_q <= ST_RESP;
          end else begin
            state_q <= ST_CMD;
          end
        end
        ST_RESP: begin
          if (clk_rise) begin
            oe_n_q <= 1'b0;
            out_q <= resp_q[15];
            resp_q <= {resp_q[14:0], 1'b0};
          end else if (clk_fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              resp_left_q <= resp_left_q - 2'h1;
              if (resp_left_q == 2'h1) begin
                oe_n_q <= 1'b1;
                state_q <= ST_CMD;
              end
            end
          end
        end
        default: begin
          state_q <= ST_CMD;
        end
      endcase
    end
  end

  // Command effects, taken in the single execute cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `CFG_RESET;
      erase_ok_q <= 1'b1;
      halt_q <= 1'b0;
      resume_q <= 1'b0;
      inject_q <= 1'b0;
      step_q <= 1'b0;
      replace_q <= 1'b0;
      erase_q <= 1'b0;
      len_q <= 2'h0;
      instr_q <= 24'h000000;
    end else begin
      halt_q <= 1'b0;
      resume_q <= 1'b0;
      inject_q <= 1'b0;
      step_q <= 1'b0;
      replace_q <= 1'b0;
      erase_q <= 1'b0;
      if (state_q == ST_EXEC) begin
        // Any command but a status read closes the erase window
        if (!is_status) begin
          erase_ok_q <= 1'b0;
        end
        if (accept) begin
          if (is_erase && erase_ok_q) begin
            erase_q <= 1'b1;
          end
          if (is_cfg_wr) begin
            cfg_q <= arg_q[7:0];
          end
          halt_q <= is_halt;
          resume_q <= is_resume;
          inject_q <= is_inject;
          step_q <= is_step;
          replace_q <= is_replace;
          if (is_inject || is_replace) begin
            len_q <= cmd_q[`CMD_COUNT_HI:`CMD_COUNT_LO];
            instr_q <= arg_q;
          end
        end
      end
    end
  end

  // Lock byte latch. A write or erase of the info page is invisible
  // here until a CPU command or a reset reloads it, so software must
  // issue a dummy no-op injection before trusting the status bit.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= `LOCK_RESET;
      load_pend_q <= 1'b1;
    end else begin
      if (load_pend_q) begin
        lock_q <= lock_byte_in;
        load_pend_q <= 1'b0;
      end else if (state_q == ST_EXEC && is_cpu_cmd) begin
        lock_q <= lock_byte_in;
      end
    end
  end

  // Flash write gating against the latched protection fields
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_q <= 1'b0;
      denied_q <= 1'b0;
    end else begin
      grant_q <= flash_wr_req & wr_ok;
      denied_q <= flash_wr_req & ~wr_ok;
    end
  end

  assign dbg_data_out = out_q;
  assign dbg_data_oe_n = oe_n_q;
  assign halt_req = halt_q;
  assign resume_req = resume_q;
  assign inject_req = inject_q;
  assign step_req = step_q;
  assign replace_req = replace_q;
  assign instr_len = len_q;
  assign instr_bytes = instr_q;
  assign erase_req = erase_q;
  // Only the debug configuration steers the info page; no CPU path
  assign info_page_select = cfg_q[`CFG_INFO_BIT];
  assign flash_wr_grant = grant_q;
  assign flash_wr_denied = denied_q;
  assign debug_locked = lock_q[`LOCK_DEBUG_BIT];
endmodule
`default_nettype wire

// *** sim/dbg_host_model.sv ***
// Behavioural debug host on the two-wire link, clocked from core_clk.
// Assumes the decoder samples on falling and drives on rising link edges.
`timescale 1ns/1ps
`default_nettype none
module dbg_host_model (
  input wire logic core_clk,
  input wire logic dbg_data_out,
  input wire logic dbg_data_oe_n,
  output logic dbg_clk_pin,
  output logic dbg_data_in
);
  logic host_bit = 1'b0;
  logic host_en = 1'b1;
  logic last_q = 1'b0;
  wire logic data_line;
  // Undriven line toggles so a stale value never reads as valid
  assign data_line = !dbg_data_oe_n ? dbg_data_out : host_en ? host_bit : ~last_q;
  assign dbg_data_in = data_line;
  initial dbg_clk_pin = 1'b0;
  always @(posedge core_clk) last_q <= data_line;
  // One byte, 200 ns per bit; link clock idles low between frames
  task automatic xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      dbg_clk_pin <= 1'b1;
      host_en <= !rd;
      host_bit <= tx[i];
      repeat (4) @(posedge core_clk);
      dbg_clk_pin <= 1'b0;
      // Sample mid-cycle, clear of the edge that may release the line
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rx[i] = data_line;
      @(posedge core_clk);
    end
    host_en <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** sim/debug_lock_command_decoder_chk.sv ***
// Port-level assertions for the debug command decoder.
// Assumes one core_clk domain and the async active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
module dbg_decoder_chk (
  input wire core_clk,
  input wire rst_n,
  input wire dbg_clk_pin,
  input wire dbg_data_out,
  input wire dbg_data_oe_n,
  input wire cpu_halted,
  input wire flash_wr_req,
  input wire halt_req,
  input wire resume_req,
  input wire inject_req,
  input wire step_req,
  input wire replace_req,
  input wire erase_req,
  input wire info_page_select,
  input wire flash_wr_grant,
  input wire flash_wr_denied,
  input wire debug_locked
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_resume_halted: assert property (
    resume_req |-> $past(cpu_halted) || $past(cpu_halted, 2)) else $error("resume while running");
  chk_exec_halted: assert property (
    inject_req || step_req || replace_req |-> $past(cpu_halted) || $past(cpu_halted, 2))
    else $error("execute while running");
  chk_halt_unlocked: assert property (
    halt_req |-> $past(debug_locked) || $past(debug_locked, 2)) else $error("halt while locked");
  chk_erase_single: assert property (
    erase_req |=> !erase_req [*8]) else $error("erase pulse repeated");
  chk_wr_answer: assert property (
    flash_wr_req |=> flash_wr_grant ^ flash_wr_denied) else $error("write not answered once");
  chk_no_stray_grant: assert property (
    flash_wr_grant || flash_wr_denied |-> $past(flash_wr_req)) else $error("unasked write answer");
  chk_info_writable: assert property (
    flash_wr_req && info_page_select |=> flash_wr_grant) else $error("info page write denied");
  chk_drive_clk_high: assert property (
    $fell(dbg_data_oe_n) |-> dbg_clk_pin || $past(dbg_clk_pin)) else $error("drive off rise");
  chk_bit_on_rise: assert property (
    !dbg_data_oe_n && $changed(dbg_data_out) |-> dbg_clk_pin || $past(dbg_clk_pin))
    else $error("answer bit moved off rise");
  cov_halt: cover property (halt_req);
  cov_denied: cover property (flash_wr_denied);
  cov_answer: cover property ($fell(dbg_data_oe_n));
endmodule
bind debug_lock_command_decoder dbg_decoder_chk dbg_decoder_chk_i (.core_clk, .rst_n,
  .dbg_clk_pin, .dbg_data_out, .dbg_data_oe_n, .cpu_halted, .flash_wr_req, .halt_req,
  .resume_req, .inject_req, .step_req, .replace_req, .erase_req, .info_page_select,
  .flash_wr_grant, .flash_wr_denied, .debug_locked);
`default_nettype wire

// *** sim/debug_lock_command_decoder_tb.sv ***
// Self-checking bench for the debug command decoder.
// Assumes the host model drives the link; status inputs are plain levels.
`timescale 1ns/1ps
`default_nettype none
module debug_lock_command_decoder_tb;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] arg;
    logic [15:0] ans;
    logic [1:0] nrx;
    logic [5:0] pulse;
  } row_t;
  logic core_clk = 1'b0;
  logic rst_n, cpu_halted, cpu_idle, power_mode0, halt_by_breakpoint, osc_stable;
  logic stack_overflow, erase_done, flash_wr_req;
  logic [15:0] pc_value;
  logic [7:0] lock_byte_in;
  logic [16:0] flash_wr_addr;
  logic [5:0] seen;
  wire dbg_clk_pin, dbg_data_in, dbg_data_out, dbg_data_oe_n, halt_req, resume_req;
  wire inject_req, step_req, replace_req, erase_req, info_page_select, flash_wr_grant;
  wire flash_wr_denied, debug_locked;
  wire [1:0] instr_len;
  wire [23:0] instr_bytes;
  int num_errors = 0;
  int comparisons = 0;
  // Pulse order: halt resume inject step replace erase
  row_t rows [12] = '{
    '{8'h34, 8'h00, 16'h00A2, 2'h1, 6'h00}, '{8'h10, 8'h00, 16'h0000, 2'h0, 6'h01},
    '{8'h19, 8'h01, 16'h0000, 2'h0, 6'h00}, '{8'h24, 8'h00, 16'h0001, 2'h1, 6'h00},
    '{8'h28, 8'h00, 16'h1234, 2'h2, 6'h00}, '{8'h68, 8'h00, 16'h5A01, 2'h2, 6'h00},
    '{8'h44, 8'h00, 16'h0000, 2'h1, 6'h20}, '{8'h4C, 8'h00, 16'h0000, 2'h1, 6'h10},
    '{8'h55, 8'h00, 16'h0000, 2'h1, 6'h08}, '{8'h5C, 8'h00, 16'h0000, 2'h1, 6'h04},
    '{8'h65, 8'hA5, 16'h0000, 2'h1, 6'h02}, '{8'h10, 8'h00, 16'h0000, 2'h0, 6'h00}};
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) seen <= seen | {halt_req, resume_req, inject_req, step_req,
    replace_req, erase_req};
  debug_lock_command_decoder debug_lock_command_decoder_i (.core_clk, .rst_n, .dbg_clk_pin,
    .dbg_data_in, .dbg_data_out, .dbg_data_oe_n, .cpu_halted, .cpu_idle, .power_mode0,
    .halt_by_breakpoint, .osc_stable, .stack_overflow, .erase_done, .pc_value, .lock_byte_in,
    .flash_wr_req, .flash_wr_addr, .halt_req, .resume_req, .inject_req, .step_req,
    .replace_req, .instr_len, .instr_bytes, .erase_req, .info_page_select, .flash_wr_grant,
    .flash_wr_denied, .debug_locked);
  dbg_host_model dbg_host_model_i (.core_clk, .dbg_data_out, .dbg_data_oe_n, .dbg_clk_pin,
    .dbg_data_in);
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input row_t r);
    logic [7:0] b;
    logic [15:0] got;
    @(negedge core_clk) seen = 6'h00;
    dbg_host_model_i.xfer(r.cmd, 1'b0, b);
    repeat (r.cmd[1:0]) dbg_host_model_i.xfer(r.arg, 1'b0, b);
    got = 16'h0000;
    repeat (r.nrx) begin
      dbg_host_model_i.xfer(8'h00, 1'b1, b);
      got = {got[7:0], b};
    end
    repeat (12) @(posedge core_clk);
    check($sformatf("answer %h", r.cmd), got, r.ans);
    check($sformatf("pulses %h", r.cmd), {10'h000, seen}, {10'h000, r.pulse});
    $display("test done: command %h", r.cmd);
  endtask
  task automatic fwrite(input logic [16:0] a, input logic ok);
    @(posedge core_clk);
    flash_wr_req <= 1'b1;
    flash_wr_addr <= a;
    @(posedge core_clk);
    flash_wr_req <= 1'b0;
    @(negedge core_clk);
    check($sformatf("write %h", a), {flash_wr_grant, flash_wr_denied}, {ok, !ok});
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1_000_000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {cpu_idle, power_mode0, halt_by_breakpoint, stack_overflow, flash_wr_req} <= 5'h00;
    {cpu_halted, osc_stable, erase_done} <= 3'h7;
    pc_value <= 16'h1234;
    flash_wr_addr <= 17'h00000;
    lock_byte_in <= 8'h01;
    do_reset();
    foreach (rows[i]) run(rows[i]);
    check("injected", {6'h00, instr_len, instr_bytes[7:0]}, 16'h01A5);
    check("info select", {15'h0000, info_page_select}, 16'h0001);
    fwrite(17'h00000, 1'b1);
    run('{8'h19, 8'h00, 16'h0000, 2'h0, 6'h00});
    fwrite(17'h1F000, 1'b0);
    @(posedge core_clk) cpu_halted <= 1'b0;
    run('{8'h4C, 8'h00, 16'h0000, 2'h1, 6'h00});
    run('{8'h56, 8'h00, 16'h0000, 2'h1, 6'h00});
    run('{8'h34, 8'h00, 16'h0082, 2'h1, 6'h00});
    @(posedge core_clk) cpu_halted <= 1'b1;
    lock_byte_in <= 8'h00;
    run('{8'h34, 8'h00, 16'h00A2, 2'h1, 6'h00});
    run('{8'h44, 8'h00, 16'h0000, 2'h1, 6'h20});
    check("locked", {15'h0000, debug_locked}, 16'h0000);
    run('{8'h34, 8'h00, 16'h00A6, 2'h1, 6'h00});
    run('{8'h24, 8'h00, 16'h0000, 2'h1, 6'h00});
    run('{8'h68, 8'h00, 16'h5A01, 2'h2, 6'h00});
    run('{8'h44, 8'h00, 16'h0000, 2'h1, 6'h00});
    lock_byte_in <= 8'h0F;
    do_reset();
    check("reset lock", {14'h0000, debug_locked, info_page_select}, 16'h0002);
    fwrite(17'h007FF, 1'b0);
    fwrite(17'h00800, 1'b1);
    fwrite(17'h1F800, 1'b1);
    $display("test done: lock and reset");
    print_verdict();
  end
endmodule
`default_nettype wire
